// ### uhft_bit_tick.sv
// Purpose: one-cycle strobe at the full-speed bit rate
// Assumes: single clock domain
// Notes: fractional accumulator, so spacing repeats 9, 8, 8 clocks
`default_nettype none
module uhft_bit_tick (
	input wire logic clk_i,
	input wire logic rst_i,
	output logic tick_o
);
	import uhft_pkg::*;

	logic [ACC_W-1:0] acc;
	logic [ACC_W-1:0] next_acc;

	always_comb begin
		next_acc = acc + ACC_STEP;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc <= '0;
			tick_o <= 1'b0;
		end else if (next_acc >= ACC_MOD) begin
			acc <= next_acc - ACC_MOD;
			tick_o <= 1'b1;
		end else begin
			acc <= next_acc;
			tick_o <= 1'b0;
		end
	end

	property p_tick_single;
		@(posedge clk_i) disable iff (rst_i) tick_o |=> !tick_o [*7];
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("bit tick spaced closer than 8 clocks");
endmodule
`default_nettype wire

// ### uhft_frame_timing.sv
// Purpose: frame timing, frame counter, periodic priority and list pointers of a usb host
// Assumes: list engine on the same clock; classic wishbone slave, one wait state
// Notes: unmapped offsets ack with zero read data and ignore writes
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`default_nettype none
module uhft_frame_timing (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [31:0] hcca_base_i,
	input wire uhft_pkg::uhft_ptr_upd_s bulk_upd_i,
	input wire uhft_pkg::uhft_ptr_upd_s done_upd_i,
	output uhft_pkg::uhft_mem_wr_s hcca_wr_o,
	output logic hcca_wr_valid_o,
	input wire logic hcca_wr_ready_i,
	output logic list_start_o,
	output logic periodic_prio_o,
	output logic [14:0] max_fullspeed_packet_bits_o,
	output logic irq_o
);
	import uhft_pkg::*;

	// byte-lane merge for wishbone writes
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	logic [27:0] bulk_current_desc_addr;
	logic [27:0] done_queue_head_addr;
	logic frame_length_toggle;
	logic [14:0] max_fullspeed_packet_bits;
	logic [13:0] frame_length_value;
	logic countdown_toggle;
	logic [13:0] frame_countdown;
	logic [15:0] frame_counter;
	logic [13:0] periodic_start_threshold;
	logic [INT_W-1:0] int_status;
	logic [INT_W-1:0] int_mask;
	logic bit_tick;
	logic frame_start;
	logic hcca_done;
	logic wr_access;
	logic [31:0] next_rdata;
	logic [31:0] flen_word;
	logic [31:0] merged;
	logic [31:0] merged_per;
	logic [31:0] merged_bulk;
	logic [INT_W-1:0] int_events;

	// register access strobe taken on the edge that raises ack
	assign wr_access = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign merged = merge_bytes(flen_word, wb_dat_i, wb_sel_i);
	// function results cannot be sliced directly, so merge into words first
	assign merged_per = merge_bytes({18'h00000, periodic_start_threshold}, wb_dat_i, wb_sel_i);
	assign merged_bulk = merge_bytes({bulk_current_desc_addr, 4'h0}, wb_dat_i, wb_sel_i);
	assign flen_word = {frame_length_toggle, max_fullspeed_packet_bits, 2'b00, frame_length_value};

	uhft_bit_tick u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_o(bit_tick)
	);

	// frame expires when the countdown sits at zero on a bit time
	assign frame_start = bit_tick && (frame_countdown == '0);

	// countdown and its toggle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_countdown <= FRAME_LEN_RST;
			countdown_toggle <= 1'b0;
		end else if (frame_start) begin
			frame_countdown <= frame_length_value;
			countdown_toggle <= frame_length_toggle;
		end else if (bit_tick) begin
			frame_countdown <= frame_countdown - 14'd1;
		end
	end

	// frame counter, rolls over naturally at 16 bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_counter <= FCNT_RST;
		end else if (frame_start) begin
			frame_counter <= frame_counter + 16'd1;
		end
	end

	// memory write must complete before sof is flagged and lists begin
	uhft_hcca_writer u_hcca (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(frame_start),
		.base_i(hcca_base_i),
		.count_i(frame_counter + 16'd1),
		.wr_o(hcca_wr_o),
		.wr_valid_o(hcca_wr_valid_o),
		.wr_ready_i(hcca_wr_ready_i),
		.done_o(hcca_done)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			list_start_o <= 1'b0;
		end else begin
			list_start_o <= hcca_done;
		end
	end

	// unsigned compare; a threshold above frame length gives periodic priority all frame
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			periodic_prio_o <= 1'b0;
		end else begin
			periodic_prio_o <= (frame_countdown <= periodic_start_threshold);
		end
	end

	// frame length configuration; toggle discipline is left to software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_length_toggle <= 1'b0;
			max_fullspeed_packet_bits <= MAX_FULLSPEED_PACKET_BITS_RST;
			frame_length_value <= FRAME_LEN_RST;
		end else if (wr_access && wb_adr_i == OFS_FRAME_LEN) begin
			frame_length_toggle <= merged[TOGGLE_BIT];
			max_fullspeed_packet_bits <= merged[MAX_FULLSPEED_PACKET_BITS_LSB +: MAX_FULLSPEED_PACKET_BITS_W];
			frame_length_value <= merged[FLEN_W-1:0];
		end
	end
	assign max_fullspeed_packet_bits_o = max_fullspeed_packet_bits;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			periodic_start_threshold <= PERIODIC_RST;
		end else if (wr_access && wb_adr_i == OFS_PERIODIC) begin
			periodic_start_threshold <= merged_per[FLEN_W-1:0];
		end
	end

	// bulk pointer: controller update wins over a software write in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bulk_current_desc_addr <= PTR_RST;
		end else if (bulk_upd_i.valid) begin
			bulk_current_desc_addr <= bulk_upd_i.addr;
		end else if (wr_access && wb_adr_i == OFS_BULK_CUR) begin
			bulk_current_desc_addr <= merged_bulk[31:PTR_LSB];
		end
	end

	// done head: no software write path at all
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_queue_head_addr <= PTR_RST;
		end else if (done_upd_i.valid) begin
			done_queue_head_addr <= done_upd_i.addr;
		end
	end

	// interrupt events; set wins over write-one-to-clear
	always_comb begin
		int_events = '0;
		int_events[INT_SOF] = hcca_done;
		int_events[INT_DONE] = done_upd_i.valid && (done_upd_i.addr != '0);
		int_events[INT_WRAP] = frame_start && (frame_counter == 16'hffff);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_status <= INT_RST;
		end else if (wr_access && wb_adr_i == OFS_INT_STATUS && wb_sel_i[0]) begin
			int_status <= (int_status & ~wb_dat_i[INT_W-1:0]) | int_events;
		end else begin
			int_status <= int_status | int_events;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_mask <= INT_RST;
		end else if (wr_access && wb_adr_i == OFS_INT_MASK && wb_sel_i[0]) begin
			int_mask <= wb_dat_i[INT_W-1:0];
		end
	end

	assign irq_o = |(int_status & int_mask);

	// read mux; reserved bits and unmapped offsets read zero
	always_comb begin
		next_rdata = 32'h00000000;
		unique case (wb_adr_i)
			OFS_BULK_CUR: next_rdata = {bulk_current_desc_addr, 4'h0};
			OFS_DONE_HEAD: next_rdata = {done_queue_head_addr, 4'h0};
			OFS_FRAME_LEN: next_rdata = flen_word;
			OFS_COUNTDOWN: next_rdata = {countdown_toggle, 17'h00000, frame_countdown};
			OFS_COUNTER: next_rdata = {16'h0000, frame_counter};
			OFS_PERIODIC: next_rdata = {18'h00000, periodic_start_threshold};
			OFS_INT_STATUS: next_rdata = {29'h0, int_status};
			OFS_INT_MASK: next_rdata = {29'h0, int_mask};
			default: next_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			wb_dat_o <= (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) ? next_rdata : 32'h00000000;
		end
	end

	// checks
	sequence s_expiry;
		bit_tick && frame_countdown == 14'd0;
	endsequence

	property p_reload;
		@(posedge clk_i) disable iff (rst_i) s_expiry |=> frame_countdown == $past(frame_length_value);
	endproperty
	a_reload: assert property (p_reload) else $error("countdown not reloaded from frame length");

	property p_toggle_copy;
		@(posedge clk_i) disable iff (rst_i) s_expiry |=> countdown_toggle == $past(frame_length_toggle);
	endproperty
	a_toggle_copy: assert property (p_toggle_copy) else $error("toggle not copied on reload");

	property p_count_inc;
		@(posedge clk_i) disable iff (rst_i) s_expiry |=> frame_counter == $past(frame_counter) + 16'd1;
	endproperty
	a_count_inc: assert property (p_count_inc) else $error("frame counter did not advance");

	property p_decrement;
		@(posedge clk_i) disable iff (rst_i)
			bit_tick && frame_countdown != 14'd0 |=> frame_countdown == $past(frame_countdown) - 14'd1;
	endproperty
	a_decrement: assert property (p_decrement) else $error("countdown did not step by one");

	property p_hold;
		@(posedge clk_i) disable iff (rst_i) !bit_tick |=> $stable(frame_countdown) && $stable(frame_counter);
	endproperty
	a_hold: assert property (p_hold) else $error("countdown moved without a bit time");

	property p_sof_after_write;
		@(posedge clk_i) disable iff (rst_i) hcca_done |=> int_status[INT_SOF] && list_start_o;
	endproperty
	a_sof_after_write: assert property (p_sof_after_write) else $error("sof or list start missing after write");

	property p_sof_needs_write;
		@(posedge clk_i) disable iff (rst_i) $rose(list_start_o) |-> $past(hcca_wr_valid_o && hcca_wr_ready_i);
	endproperty
	a_sof_needs_write: assert property (p_sof_needs_write) else $error("lists started before memory write");

	property p_prio;
		@(posedge clk_i) disable iff (rst_i)
			frame_countdown <= periodic_start_threshold ##1 $stable(periodic_start_threshold) |-> periodic_prio_o;
	endproperty
	a_prio: assert property (p_prio) else $error("periodic priority not granted");

	property p_done_ro;
		@(posedge clk_i) disable iff (rst_i)
			wr_access && wb_adr_i == OFS_DONE_HEAD && !done_upd_i.valid |=> $stable(done_queue_head_addr);
	endproperty
	a_done_ro: assert property (p_done_ro) else $error("software changed the done head");

	property p_bulk_end;
		@(posedge clk_i) disable iff (rst_i)
			bulk_upd_i.valid && bulk_upd_i.addr == '0 |=> bulk_current_desc_addr == 28'h0;
	endproperty
	a_bulk_end: assert property (p_bulk_end) else $error("bulk pointer not zero at list end");
endmodule
`default_nettype wire

// ### uhft_frame_timing_tb_top.sv
// Purpose: self-checking bench for the frame timing and list pointer block
// Assumes: 100 MHz clock; the first frame runs at the reset length, so the run is about 100k cycles
// Notes: later frames are shortened by software so several of them fit in the run
`default_nettype none
module uhft_frame_timing_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import uhft_pkg::*;
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, hval, hrdy, lstart, prio, irq, acc;
	logic hval_q = 1'b0, prio_rise = 1'b0, lstart_seen = 1'b0, tog = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] dat_w = '0, dat_r, base = '0, q, v;
	logic [13:0] flen, pth;
	logic [14:0] fs, mfsp;
	uhft_ptr_upd_s bulk_upd = '0, done_upd = '0;
	uhft_mem_wr_s hwr, last;
	integer seed, num_errors = 0, num_checks = 0, ncyc = 0, trise = 0, per = 0;
	always #5 clk = ~clk;
	uhft_frame_timing DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
		.hcca_base_i(base), .bulk_upd_i(bulk_upd), .done_upd_i(done_upd), .hcca_wr_o(hwr),
		.hcca_wr_valid_o(hval), .hcca_wr_ready_i(hrdy), .list_start_o(lstart), .periodic_prio_o(prio),
		.max_fullspeed_packet_bits_o(mfsp), .irq_o(irq));
	uhft_mem_model MEM (.clk_i(clk), .rst_i(rst), .wr_i(hwr), .valid_i(hval), .ready_o(hrdy),
		.acc_o(acc), .last_o(last));
	// frame period measured between rises of the memory request
	always @(posedge clk) begin
		ncyc <= ncyc + 1;
		hval_q <= hval;
		if (hval === 1'b1 && hval_q === 1'b0) begin
			per <= ncyc - trise;
			trise <= ncyc;
			prio_rise <= prio;
			lstart_seen <= 1'b0;
		end
		if (acc === 1'b1) begin
			lstart_seen <= (lstart === 1'b1);
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk({63'h0, got}, {63'h0, exp});
	endtask
	task automatic final_report();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// held until the ack edge, then released for one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) begin
			num_errors++;
			final_report();
		end
		@(posedge clk);
	endtask
	task automatic wait_acc();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (acc !== 1'b1 && n < 120000);
		if (n >= 120000) begin
			num_errors++;
			final_report();
		end
	endtask
	function automatic int frame_clocks(input logic [13:0] len);
		return (int'(len) + 1) * 100 / 12;
	endfunction
	initial begin
		seed = 32'hc5349416;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		base <= $random(seed) & 32'hffffff00;
		@(posedge clk);
		wb(0, OFS_FRAME_LEN, 0, q);
		chk(q, {18'h0, FRAME_LEN_RST});
		wb(0, OFS_COUNTER, 0, q);
		chk(q, 0);
		wb(0, OFS_DONE_HEAD, 0, q);
		chk(q, 0);
		$display("test reset values done");
		v = $random(seed);
		wb(1, OFS_BULK_CUR, v, q);
		wb(0, OFS_BULK_CUR, 0, q);
		chk(q, {v[31:4], 4'h0});
		wb(1, OFS_DONE_HEAD, v, q);
		wb(0, OFS_DONE_HEAD, 0, q);
		chk(q, 0);
		bulk_upd <= '{1'b1, 28'h0};
		done_upd <= '{1'b1, v[31:4]};
		@(posedge clk);
		bulk_upd <= '0;
		done_upd <= '0;
		@(posedge clk);
		wb(0, OFS_BULK_CUR, 0, q);
		chk(q, 0);
		wb(0, OFS_DONE_HEAD, 0, q);
		chk(q, {v[31:4], 4'h0});
		wb(0, OFS_INT_STATUS, 0, q);
		chkb(q[INT_DONE], 1'b1);
		wb(1, OFS_INT_STATUS, 32'h7, q);
		wb(0, OFS_INT_STATUS, 0, q);
		chk(q, 0);
		wb(1, 8'h20, v, q);
		wb(0, 8'h20, 0, q);
		chk(q, 0);
		$display("test pointers done");
		flen = 14'h40 | 14'($random(seed) & 32'h3f);
		pth = flen - flen / 10;
		fs = 15'($random(seed));
		wb(1, OFS_FRAME_LEN, {tog, fs, 2'b00, flen}, q);
		chk({49'h0, mfsp}, {49'h0, fs});
		wb(0, OFS_FRAME_LEN, 0, q);
		chk(q, {tog, fs, 2'b00, flen});
		wb(1, OFS_PERIODIC, {18'h0, pth}, q);
		wb(1, OFS_INT_MASK, 32'h1, q);
		for (int f = 1; f <= 5; f++) begin
			wait_acc();
			chk(last, {base + HCCA_FCNT_OFS, 16'h0, 16'(f)});
			repeat (2) @(posedge clk);
			chkb(lstart_seen, 1'b1);
			chkb(lstart, 1'b0);
			chkb(prio, 1'b0);
			if (f > 1) begin
				chkb(prio_rise, 1'b1);
			end
			wb(0, OFS_COUNTDOWN, 0, q);
			chkb(q[TOGGLE_BIT], tog);
			chkb(q[13:0] <= flen && q[13:0] > pth, 1'b1);
			wb(0, OFS_COUNTER, 0, q);
			chk(q, 32'(f));
			if (f == 2) begin
				tog = 1'b0;
				wb(1, OFS_FRAME_LEN, {tog, fs, 2'b00, flen}, q);
			end
			if (f > 2) begin
				chkb(per >= frame_clocks(flen) - 2 && per <= frame_clocks(flen) + 2, 1'b1);
			end
			if (f == 3) begin
				chkb(irq, 1'b1);
				wb(1, OFS_INT_STATUS, 32'h1, q);
				chkb(irq, 1'b0);
				wb(1, OFS_INT_MASK, 32'h0, q);
			end
			if (f == 4) begin
				chkb(irq, 1'b0);
				wb(0, OFS_INT_STATUS, 0, q);
				chkb(q[INT_SOF], 1'b1);
			end
			$display("test frame %0d done", f);
		end
		final_report();
	end
endmodule
`default_nettype wire

// ### uhft_hcca_writer.sv
// Purpose: writes the new frame counter value into host memory
// Assumes: memory port accepts on valid and ready in the same cycle
// Notes: a start while busy is dropped; frames are far longer than any memory stall
`default_nettype none
module uhft_hcca_writer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [31:0] base_i,
	input wire logic [15:0] count_i,
	output uhft_pkg::uhft_mem_wr_s wr_o,
	output logic wr_valid_o,
	input wire logic wr_ready_i,
	output logic done_o
);
	import uhft_pkg::*;

	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_BUSY = 2'b10
	} uhft_wr_state_e;

	uhft_wr_state_e state;

	assign wr_valid_o = (state == WR_BUSY);
	assign done_o = wr_valid_o && wr_ready_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= WR_IDLE;
		end else begin
			unique case (state)
				WR_IDLE: begin
					if (start_i) begin
						state <= WR_BUSY;
					end
				end
				WR_BUSY: begin
					if (wr_ready_i) begin
						state <= WR_IDLE;
					end
				end
				default: begin
					state <= WR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_o <= '0;
		end else if (start_i && state == WR_IDLE) begin
			wr_o.addr <= base_i + HCCA_FCNT_OFS;
			wr_o.data <= {16'h0000, count_i};
		end
	end

	sequence s_wr_started;
		(state == WR_IDLE) && start_i;
	endsequence
	property p_wr_carries_count;
		@(posedge clk_i) disable iff (rst_i) s_wr_started |=> wr_valid_o && wr_o.data[15:0] == $past(count_i);
	endproperty
	a_wr_carries_count: assert property (p_wr_carries_count) else $error("memory write lost the frame count");
endmodule
`default_nettype wire

// ### uhft_mem_model.sv
// Purpose: host memory stand-in that accepts the frame counter writes
// Assumes: the writer holds valid and data until ready
// Notes: ready stalls at random so a writer that drops its request early is caught
`default_nettype none
module uhft_mem_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire uhft_pkg::uhft_mem_wr_s wr_i,
	input wire logic valid_i,
	output logic ready_o,
	output logic acc_o,
	output uhft_pkg::uhft_mem_wr_s last_o
);
	timeunit 1ns;
	timeprecision 1ps;
	integer pseed = 32'h1234abcd;
	always @(posedge clk_i) begin
		if (rst_i) begin
			ready_o <= 1'b0;
			acc_o <= 1'b0;
			last_o <= '0;
		end else begin
			ready_o <= ($random(pseed) & 3) == 0;
			acc_o <= valid_i && ready_o;
			if (valid_i && ready_o) begin
				last_o <= wr_i;
			end
		end
	end
endmodule
`default_nettype wire

// ### uhft_pkg.sv
// Purpose: constants and carriers for the usb host frame timing and list pointer block
// Assumes: 100 MHz system clock, classic wishbone register access
// Notes: full-speed bit times are derived from the system clock by a fractional tick
`default_nettype none
package uhft_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_BULK_CUR = 8'h00;
	localparam logic [7:0] OFS_DONE_HEAD = 8'h04;
	localparam logic [7:0] OFS_FRAME_LEN = 8'h08;
	localparam logic [7:0] OFS_COUNTDOWN = 8'h0c;
	localparam logic [7:0] OFS_COUNTER = 8'h10;
	localparam logic [7:0] OFS_PERIODIC = 8'h14;
	localparam logic [7:0] OFS_INT_STATUS = 8'h18;
	localparam logic [7:0] OFS_INT_MASK = 8'h1c;

	// field positions
	localparam int PTR_LSB = 4;
	localparam int FLEN_W = 14;
	localparam int MAX_FULLSPEED_PACKET_BITS_LSB = 16;
	localparam int MAX_FULLSPEED_PACKET_BITS_W = 15;
	localparam int TOGGLE_BIT = 31;
	localparam int FCNT_W = 16;
	localparam int INT_W = 3;
	localparam int INT_SOF = 0;
	localparam int INT_DONE = 1;
	localparam int INT_WRAP = 2;

	// reset values
	localparam logic [13:0] FRAME_LEN_RST = 14'h2edf;
	localparam logic [14:0] MAX_FULLSPEED_PACKET_BITS_RST = 15'h0000;
	localparam logic [13:0] PERIODIC_RST = 14'h0000;
	localparam logic [15:0] FCNT_RST = 16'h0000;
	localparam logic [27:0] PTR_RST = 28'h0000000;
	localparam logic [INT_W-1:0] INT_RST = 3'h0;

	// frame counter location within the shared host memory area
	localparam logic [31:0] HCCA_FCNT_OFS = 32'h00000080;

	// timing: accumulate bit rate per clock, wrap at clock rate
	localparam int CLK_KHZ = 100_000;
	localparam int BIT_KHZ = 12_000;
	localparam int ACC_W = 17;
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(BIT_KHZ);
	localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_KHZ);

	typedef struct packed {
		logic valid;
		logic [27:0] addr;
	} uhft_ptr_upd_s;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
	} uhft_mem_wr_s;
endpackage
`default_nettype wire
